// *** hw/sfp_pkg.sv ***
// constants, types and register map of the static friction fault predictor
// assumes a 100 MHz core clock and an APB slave port with 32-bit data
package sfp_pkg;

    // apb register byte offsets
    localparam logic [7:0] SFP_OFS_MODE     = 8'h00;
    localparam logic [7:0] SFP_OFS_MULT     = 8'h04;
    localparam logic [7:0] SFP_OFS_DIR      = 8'h08;
    localparam logic [7:0] SFP_OFS_STRETCH  = 8'h0C;
    localparam logic [7:0] SFP_OFS_AVERAGE  = 8'h10;
    localparam logic [7:0] SFP_OFS_STDDEV   = 8'h14;
    localparam logic [7:0] SFP_OFS_STATUS   = 8'h18;
    localparam logic [7:0] SFP_OFS_UPPER    = 8'h1C;
    localparam logic [7:0] SFP_OFS_LOWER    = 8'h20;
    localparam logic [7:0] SFP_OFS_PROGRESS = 8'h24;
    localparam logic [7:0] SFP_OFS_CONTROL  = 8'h28;

    // field positions
    localparam int SFP_STATUS_LSB  = 20;
    localparam int SFP_CTRL_SWRST  = 0;

    // reset values
    localparam logic [3:0]  SFP_MODE_RST    = 4'h0;
    localparam logic [3:0]  SFP_MULT_RST    = 4'h0;
    localparam logic [1:0]  SFP_DIR_RST     = 2'h0;
    localparam logic [31:0] SFP_STRETCH_RST = 32'h0000_0000;
    localparam logic [15:0] SFP_STAT_RST    = 16'h0000;

    // warning mode field encodings
    localparam logic [3:0] SFP_MODE_OFF    = 4'h0;
    localparam logic [3:0] SFP_MODE_AUTO   = 4'h1;
    localparam logic [3:0] SFP_MODE_MANUAL = 4'h2;
    localparam logic [3:0] SFP_MODE_RESET  = 4'h3;

    // direction select encodings
    localparam logic [1:0] SFP_DIR_FWD = 2'h0;
    localparam logic [1:0] SFP_DIR_REV = 2'h1;

    // status nibble encodings
    localparam logic [3:0] SFP_ST_DISABLED = 4'h0;
    localparam logic [3:0] SFP_ST_PREPARE  = 4'h1;
    localparam logic [3:0] SFP_ST_WARNING  = 4'h2;
    localparam logic [3:0] SFP_ST_WATCH    = 4'h3;

    // arithmetic constants
    localparam logic [3:0]  SFP_MULT_DEFAULT  = 4'h5;
    localparam logic [35:0] SFP_REVS_PER_UNIT = 36'h0_0000_000A;
    localparam logic [4:0]  SFP_SAMPLES       = 5'h10;
    localparam int          SFP_SAMPLE_SHIFT  = 4;
    localparam logic [11:0] SFP_PCT_FULL      = 12'h064;
    localparam logic [3:0]  SFP_ROOT_MSB      = 4'hF;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int RUN_TIME_H = 3;
    localparam int RUN_TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int RUN_TICKS_DEF = RUN_TIME_H * 3600 * 1000;

    // one static friction estimate from the estimator
    typedef struct packed {
        logic               valid;
        logic               reverse;
        logic signed [15:0] value;
    } sfp_sample_s;

    // active limit pair
    typedef struct packed {
        logic signed [21:0] upper;
        logic signed [21:0] lower;
    } sfp_limits_s;

    // threshold derivation sequencer
    typedef enum logic [1:0] {
        SFP_IDLE    = 2'b00,
        SFP_COLLECT = 2'b01,
        SFP_ROOT    = 2'b10,
        SFP_COMMIT  = 2'b11
    } sfp_state_e;

endpackage

// *** hw/sfp_predictor.sv ***
// static friction fault predictor: apb registers, threshold derivation,
// limit computation and machine diagnosis warning
// assumes the friction estimator, travel accumulator and run detector share
// i_core_clk; software reaches all settings over apb
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none

// Operation
// [R01] mode field: 0 disabled, 1 automatic, 2 manual, 3 pending threshold reset
// [R02] automatic derivation waits three hours running and estimation done
// [R03] automatic derivation skipped while travel below stretch setting
// [R04] stretch setting counts ten motor revolutions per unit
// [R05] automatic mode overwrites stored average and deviation
// [R06] automatic completion switches mode field to manual
// [R07] upper limit is average plus deviation times multiplier
// [R08] lower limit is average minus deviation times multiplier
// [R09] multiplier zero acts as five
// [R10] multiplier resets to zero
// [R11] average setting resets to zero, used as written in manual mode
// [R12] deviation setting resets to zero, used as written in manual mode
// [R13] pending reset at software reset clears thresholds, mode to automatic
// [R14] monitoring starts only once valid limits exist
// [R15] warning while estimate above upper limit
// [R16] warning while estimate below lower limit
// [R17] warning withdrawn when estimate back inside limits
// [R18] status nibble bits 20-23: 0 off, 1 preparing, 2 warning
// [R19] active upper and lower limits readable
// [R20] derivation progress in percent, 100 when limits created
// [R21] compare on each new estimate, signed arithmetic
// [R22] disabled mode keeps warning low, no derivation
module sfp_predictor
    import sfp_pkg::*;
#(
    parameter int RUN_TICK_CYCLES = RUN_TICK_CYCLES_DEF,
    parameter int RUN_TICKS       = RUN_TICKS_DEF
) (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_srst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // estimator and machine side
    input  wire sfp_sample_s i_sample,
    input  wire logic        i_est_done_fwd,
    input  wire logic        i_est_done_rev,
    input  wire logic        i_equipment_running,
    input  wire logic [31:0] i_travel_revs,
    // results
    output logic             o_machine_diagnosis_warning,
    output logic      [3:0]  o_status_nibble
);

    // sign extension to a bus word
    function automatic logic [31:0] sext22(input logic signed [21:0] v);
        sext22 = {{10{v[21]}}, v};
    endfunction

    // registers
    logic        [3:0]  warning_mode_select;
    logic        [3:0]  limit_multiplier;
    logic        [1:0]  friction_direction_select;
    logic        [31:0] stretch_travel_distance;
    logic signed [15:0] friction_mean_setting;
    logic        [15:0] friction_spread_setting;

    // hardware owned
    logic        [6:0]  progress;
    logic               machine_diagnosis_warning;

    // run-time qualification
    logic [31:0] tick_cnt;
    logic [31:0] run_ticks;
    logic        run_ok;

    // derivation datapath
    sfp_state_e          state;
    sfp_state_e          next_state;
    logic        [4:0]   sample_cnt;
    logic signed [19:0]  sum;
    logic        [35:0]  sum_sq;

    // root search
    logic        [15:0]  root;
    logic        [3:0]   root_bit;

    // apb decode
    wire         apb_access = i_psel & i_penable;
    wire         apb_commit = apb_access & o_pready;
    wire         wr_en      = apb_commit & i_pwrite;

    // word hits
    wire         hit_mode   = i_paddr == SFP_OFS_MODE;
    wire         hit_mult   = i_paddr == SFP_OFS_MULT;
    wire         hit_dir    = i_paddr == SFP_OFS_DIR;
    wire         hit_str    = i_paddr == SFP_OFS_STRETCH;
    wire         hit_avg    = i_paddr == SFP_OFS_AVERAGE;
    wire         hit_std    = i_paddr == SFP_OFS_STDDEV;
    wire         hit_stat   = i_paddr == SFP_OFS_STATUS;
    wire         hit_up     = i_paddr == SFP_OFS_UPPER;
    wire         hit_lo     = i_paddr == SFP_OFS_LOWER;
    wire         hit_prog   = i_paddr == SFP_OFS_PROGRESS;
    wire         hit_ctrl   = i_paddr == SFP_OFS_CONTROL;

    // mapped or not
    wire         hit_any    = hit_mode | hit_mult | hit_dir | hit_str |
                              hit_avg | hit_std | hit_stat | hit_up |
                              hit_lo | hit_prog | hit_ctrl;

    // reset command
    wire         sw_reset   = wr_en & hit_ctrl & i_pwdata[SFP_CTRL_SWRST];

    // mode decode
    wire         mode_auto   = warning_mode_select == SFP_MODE_AUTO;
    wire         mode_manual = warning_mode_select == SFP_MODE_MANUAL;
    wire         mode_off    = warning_mode_select == SFP_MODE_OFF;
    wire         mode_clear  = warning_mode_select == SFP_MODE_RESET;

    // limit arithmetic
    wire  [3:0]  eff_mult = (limit_multiplier == 4'h0) ?
                            SFP_MULT_DEFAULT : limit_multiplier; // see [R09]
    wire  [19:0] spread_x = friction_spread_setting * eff_mult;
    wire signed [21:0] mean_w   = 22'(friction_mean_setting);
    wire signed [21:0] spread_w = $signed({2'b00, spread_x});

    // signed limits
    sfp_limits_s limits;
    assign limits.upper = mean_w + spread_w; // see [R07]
    assign limits.lower = mean_w - spread_w; // see [R08]

    // estimate qualification
    wire signed [21:0] est_w   = 22'(i_sample.value);
    wire         est_above = est_w > limits.upper; // see [R21]
    wire         est_below = est_w < limits.lower; // see [R21]

    // travel gate
    wire  [35:0] stretch_revs = 36'(stretch_travel_distance) *
                                SFP_REVS_PER_UNIT; // see [R04]
    wire         travel_ok = {4'h0, i_travel_revs} >= stretch_revs;
    wire         est_ok    = (friction_direction_select == SFP_DIR_FWD) ?
                             i_est_done_fwd :
                             (friction_direction_select == SFP_DIR_REV) ?
                             i_est_done_rev :
                             (i_est_done_fwd & i_est_done_rev);

    // direction match
    wire         dir_match = (friction_direction_select == SFP_DIR_FWD) ?
                             !i_sample.reverse :
                             (friction_direction_select == SFP_DIR_REV) ?
                             i_sample.reverse : 1'b1;

    // derivation gate
    wire         eligible  = mode_auto & run_ok & est_ok &
                             travel_ok; // see [R02] see [R03]
    wire         take      = eligible & i_sample.valid & dir_match;

    // statistics of the collected set
    wire signed [15:0] mean_c  = 16'(sum >>> SFP_SAMPLE_SHIFT);
    wire signed [31:0] mean_sq = mean_c * mean_c;
    wire        [31:0] mean_sq_u = mean_sq;
    wire        [31:0] sq_avg  = 32'(sum_sq >> SFP_SAMPLE_SHIFT);
    wire        [31:0] variance = (sq_avg > mean_sq_u) ?
                                  (sq_avg - mean_sq_u) : 32'h0000_0000;

    // root trial
    wire        [15:0] root_try = root | (16'h0001 << root_bit);
    wire        [31:0] try_sq   = root_try * root_try;

    // sample square
    wire        [15:0] abs_v    = i_sample.value[15] ?
                                  16'(-i_sample.value) : i_sample.value;
    wire        [31:0] sample_sq = abs_v * abs_v;

    // progress percent
    wire        [11:0] prog_x   = 12'(sample_cnt) * SFP_PCT_FULL;
    wire        [6:0]  prog_now = 7'(prog_x >> SFP_SAMPLE_SHIFT);
    wire               derived  = state == SFP_COMMIT;

    // warning counts in manual mode only
    wire         warn_live  = machine_diagnosis_warning & mode_manual;

    // status nibble
    wire  [3:0]  status_now = (mode_off | mode_clear) ? SFP_ST_DISABLED :
                              mode_auto ? SFP_ST_PREPARE :
                              warn_live ? SFP_ST_WARNING :
                              SFP_ST_WATCH; // see [R18]

    // read data
    wire  [31:0] rd_mux =
        hit_mode ? {28'h0, warning_mode_select} :
        hit_mult ? {28'h0, limit_multiplier} :
        hit_dir  ? {30'h0, friction_direction_select} :
        hit_str  ? stretch_travel_distance :
        hit_avg  ? {16'h0, friction_mean_setting} :
        hit_std  ? {16'h0, friction_spread_setting} :
        hit_stat ? {8'h0, status_now, 20'h0} :
        hit_up   ? sext22(limits.upper) : // see [R19]
        hit_lo   ? sext22(limits.lower) : // see [R19]
        hit_prog ? {25'h0, progress} :    // see [R20]
        32'h0000_0000;

    // apb answer: one wait state, data and error registered
    // unmapped: error, zero data
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= apb_access & !o_pready;
            o_prdata  <= (apb_access & !o_pready & !i_pwrite) ?
                         rd_mux : 32'h0000_0000;
            o_pslverr <= apb_access & !o_pready & !hit_any;
        end
    end

    // continuous running qualification, ms tick from a divider
    // a stop restarts the count
    always_ff @(posedge i_core_clk) begin
        if (i_srst | !i_equipment_running) begin
            tick_cnt  <= 32'h0000_0000;
            run_ticks <= 32'h0000_0000;
            run_ok    <= 1'b0;
        end else if (tick_cnt == 32'(RUN_TICK_CYCLES - 1)) begin
            tick_cnt  <= 32'h0000_0000;
            if (!run_ok) begin
                run_ticks <= run_ticks + 32'h0000_0001;
            end
            run_ok <= run_ticks >= 32'(RUN_TICKS - 1); // see [R02]
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end

    // derivation sequencer next state
    // leaving auto drops the set
    always_comb begin
        next_state = state;
        unique case (state)
            SFP_IDLE: begin
                if (take) begin
                    next_state = SFP_COLLECT;
                end
            end
            SFP_COLLECT: begin
                if (!mode_auto) begin
                    next_state = SFP_IDLE;
                end else if (sample_cnt == SFP_SAMPLES) begin
                    next_state = SFP_ROOT;
                end
            end
            SFP_ROOT: begin
                if (!mode_auto) begin
                    next_state = SFP_IDLE;
                end else if (root_bit == 4'h0) begin
                    next_state = SFP_COMMIT;
                end
            end
            SFP_COMMIT: begin
                next_state = SFP_IDLE;
            end
        endcase
    end

    // sample accumulation and square root, one bit per cycle
    // set stops at the sample count
    always_ff @(posedge i_core_clk) begin
        if (i_srst | !mode_auto) begin // see [R22]
            state      <= SFP_IDLE;
            sample_cnt <= 5'h00;
            sum        <= 20'sh00000;
            sum_sq     <= 36'h0_0000_0000;
            root       <= 16'h0000;
            root_bit   <= SFP_ROOT_MSB;
        end else begin
            state <= next_state;
            if (take & (sample_cnt != SFP_SAMPLES)) begin
                sample_cnt <= sample_cnt + 5'h01;
                sum        <= sum + 20'(i_sample.value);
                sum_sq     <= sum_sq + 36'(sample_sq);
            end
            if (state == SFP_ROOT) begin
                if (try_sq <= variance) begin
                    root <= root_try;
                end
                root_bit <= root_bit - 4'h1;
            end
        end
    end

    // software settings, hardware updates take precedence
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            warning_mode_select       <= SFP_MODE_RST;  // see [R01]
            limit_multiplier          <= SFP_MULT_RST;  // see [R10]
            friction_direction_select <= SFP_DIR_RST;
            stretch_travel_distance   <= SFP_STRETCH_RST;
            friction_mean_setting     <= SFP_STAT_RST;  // see [R11]
            friction_spread_setting   <= SFP_STAT_RST;  // see [R12]
            progress                  <= 7'h00;
        end else begin
            if (wr_en & hit_mode) begin
                warning_mode_select <= i_pwdata[3:0];
            end
            if (wr_en & hit_mult) begin
                limit_multiplier <= i_pwdata[3:0];
            end
            if (wr_en & hit_dir) begin
                friction_direction_select <= i_pwdata[1:0];
            end
            if (wr_en & hit_str) begin
                stretch_travel_distance <= i_pwdata;
            end
            if (wr_en & hit_avg) begin
                friction_mean_setting <= i_pwdata[15:0];
            end
            if (wr_en & hit_std) begin
                friction_spread_setting <= i_pwdata[15:0];
            end

            // held at 99 until commit
            if (mode_auto & (state != SFP_COMMIT)) begin
                progress <= (prog_now == SFP_PCT_FULL[6:0]) ?
                            7'h63 : prog_now; // see [R20]
            end

            // commit beats writes
            if (derived) begin
                friction_mean_setting   <= mean_c;           // see [R05]
                friction_spread_setting <= root;             // see [R05]
                warning_mode_select     <= SFP_MODE_MANUAL;  // see [R06]
                progress                <= SFP_PCT_FULL[6:0]; // see [R20]
            end

            // threshold reset beats all
            if (sw_reset & mode_clear) begin
                friction_mean_setting   <= SFP_STAT_RST;     // see [R13]
                friction_spread_setting <= SFP_STAT_RST;     // see [R13]
                warning_mode_select     <= SFP_MODE_AUTO;    // see [R13]
                progress                <= 7'h00;
            end
        end
    end

    // warning: only with established limits, re-judged per estimate
    always_ff @(posedge i_core_clk) begin
        if (i_srst | !mode_manual) begin // see [R14] see [R22]
            machine_diagnosis_warning <= 1'b0;
        end else if (i_sample.valid) begin
            machine_diagnosis_warning <= est_above |  // see [R15]
                                         est_below;   // see [R16] see [R17]
        end
    end

    // registered result outputs
    // same cycle for both outputs
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_machine_diagnosis_warning <= 1'b0;
            o_status_nibble             <= SFP_ST_DISABLED;
        end else begin
            o_machine_diagnosis_warning <= warn_live;
            o_status_nibble             <= status_now;
        end
    end

endmodule
`default_nettype wire

// *** sim/sfp_predictor_props.sv ***
// port checker for the static friction fault predictor
// assumes bind onto sfp_predictor, one clock domain, sync active-high reset
`timescale 1ns/1ns
`default_nettype none
module sfp_predictor_props
    import sfp_pkg::*;
(
    // clock and reset
    input wire logic        i_core_clk,
    input wire logic        i_srst,
    // apb
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // estimator and results
    input wire sfp_sample_s i_sample,
    input wire logic        o_machine_diagnosis_warning,
    input wire logic [3:0]  o_status_nibble
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    // apb answer timing and data
    a_ready_one_wait: assert property (
        i_psel && i_penable && !$past(i_penable) |=> o_pready)
        else $error("pready not in second access cycle");
    a_ready_one_cycle: assert property (
        o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    a_error_zero_data: assert property (
        o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("slverr without pready or with data");
    a_idle_data_zero: assert property (
        !o_pready |-> o_prdata == 32'h0)
        else $error("read data outside answer cycle");
    // warning tied to estimates and status
    a_warn_from_sample: assert property (
        $rose(o_machine_diagnosis_warning) |-> $past(i_sample.valid, 2))
        else $error("warning rose without a sample");
    a_warn_drop_sample: assert property (
        $fell(o_machine_diagnosis_warning) &&
        o_status_nibble == SFP_ST_WATCH |-> $past(i_sample.valid, 2))
        else $error("warning withdrawn without a sample");
    a_warn_status_two: assert property (
        o_machine_diagnosis_warning |-> o_status_nibble == SFP_ST_WARNING)
        else $error("warning without status two");
    a_status_no_warn: assert property (
        !o_machine_diagnosis_warning |->
        o_status_nibble != SFP_ST_WARNING)
        else $error("status two without warning");
    a_reset_quiet: assert property (
        $fell(i_srst) |-> !o_pready && !o_machine_diagnosis_warning &&
        o_status_nibble == SFP_ST_DISABLED)
        else $error("outputs not quiet after reset");

    // main scenarios reached
    c_warning: cover property ($rose(o_machine_diagnosis_warning));
    c_slverr: cover property (o_pslverr);
    c_prepare: cover property (o_status_nibble == SFP_ST_PREPARE);
endmodule

bind sfp_predictor sfp_predictor_props u_props (
    .i_core_clk                  (i_core_clk),
    .i_srst                      (i_srst),
    .i_psel                      (i_psel),
    .i_penable                   (i_penable),
    .o_prdata                    (o_prdata),
    .o_pready                    (o_pready),
    .o_pslverr                   (o_pslverr),
    .i_sample                    (i_sample),
    .o_machine_diagnosis_warning (o_machine_diagnosis_warning),
    .o_status_nibble             (o_status_nibble)
);
`default_nettype wire

// *** sim/sfp_predictor_bench.sv ***
// self-checking bench of the static friction fault predictor
// assumes short run-time parameters; bench acts as apb master and estimator
`timescale 1ns/1ns
`default_nettype none
module sfp_predictor_bench
    import sfp_pkg::*;
;
    logic        i_core_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_psel = 1'b0;
    logic        i_penable = 1'b0;
    logic        i_pwrite = 1'b0;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    sfp_sample_s i_sample = '0;
    logic        i_est_done_fwd = 1'b0;
    logic        i_est_done_rev = 1'b0;
    logic        i_equipment_running = 1'b1;
    logic [31:0] i_travel_revs = 32'h0;
    logic        o_machine_diagnosis_warning;
    logic [3:0]  o_status_nibble;
    logic [31:0] rd;
    logic        err;
    int          errors = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    sfp_predictor #(.RUN_TICK_CYCLES(4), .RUN_TICKS(3)) uut (
        .i_core_clk(i_core_clk), .i_srst(i_srst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_sample(i_sample),
        .i_est_done_fwd(i_est_done_fwd), .i_est_done_rev(i_est_done_rev),
        .i_equipment_running(i_equipment_running),
        .i_travel_revs(i_travel_revs),
        .o_machine_diagnosis_warning(o_machine_diagnosis_warning),
        .o_status_nibble(o_status_nibble));

    // 100 MHz clock
    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr_en, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge i_core_clk);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= wr_en;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        do @(posedge i_core_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask

    // one estimate pulse, outputs judged two edges after it is taken
    task automatic smp(input logic [15:0] v, input logic w,
                       input logic [3:0] st);
        @(posedge i_core_clk);
        i_sample <= '{valid: 1'b1, reverse: 1'b0, value: v};
        @(posedge i_core_clk);
        i_sample.valid <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        #1;
        chk({31'h0, o_machine_diagnosis_warning}, {31'h0, w}, "warning");
        chk({28'h0, o_status_nibble}, {28'h0, st}, "status nibble");
    endtask

    task automatic lim(input logic [15:0] a, input logic [15:0] s,
                       input logic [3:0] m, input logic [31:0] up,
                       input logic [31:0] lo);
        wr(SFP_OFS_AVERAGE, {16'h0, a});
        wr(SFP_OFS_STDDEV, {16'h0, s});
        wr(SFP_OFS_MULT, {28'h0, m});
        rdc(SFP_OFS_UPPER, up, "upper limit");
        rdc(SFP_OFS_LOWER, lo, "lower limit");
    endtask

    // reset values, narrow readback and an unmapped place
    task automatic t_regs();
        logic [7:0] ofs [6] = '{SFP_OFS_MODE, SFP_OFS_MULT, SFP_OFS_DIR,
            SFP_OFS_STRETCH, SFP_OFS_AVERAGE, SFP_OFS_STDDEV};
        foreach (ofs[i]) begin
            rdc(ofs[i], 32'h0, "reset value");
        end
        wr(SFP_OFS_MULT, 32'hFFFF_FFF7);
        rdc(SFP_OFS_MULT, 32'h7, "multiplier");
        wr(8'h2C, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1, "unmapped write error");
        rdc(8'h2C, 32'h0, "unmapped read");
        chk({31'h0, err}, 32'h1, "unmapped read error");
    endtask

    // manual limits and the warning window
    task automatic t_manual();
        wr(SFP_OFS_MODE, {28'h0, SFP_MODE_MANUAL});
        lim(16'h000A, 16'h0014, 4'h0, 32'h6E, 32'hFFFF_FFA6);
        lim(16'h0064, 16'h000A, 4'h3, 32'h82, 32'h46);
        lim(16'h0064, 16'h000A, 4'h0, 32'h96, 32'h32);
        smp(16'h00C8, 1'b1, SFP_ST_WARNING);
        rdc(SFP_OFS_STATUS, 32'h0020_0000, "status word");
        smp(16'h0096, 1'b0, SFP_ST_WATCH);
        smp(16'h0032, 1'b0, SFP_ST_WATCH);
        smp(16'h0031, 1'b1, SFP_ST_WARNING);
        smp(16'h0064, 1'b0, SFP_ST_WATCH);
        wr(SFP_OFS_MODE, {28'h0, SFP_MODE_OFF});
        smp(16'h01F4, 1'b0, SFP_ST_DISABLED);
        wr(SFP_OFS_MODE, {28'h0, SFP_MODE_RESET});
        smp(16'h01F4, 1'b0, SFP_ST_DISABLED);
    endtask

    // automatic derivation gates, results and threshold reset
    task automatic t_auto();
        wr(SFP_OFS_MODE, {28'h0, SFP_MODE_OFF});
        wr(SFP_OFS_STRETCH, 32'h2);
        i_travel_revs  <= 32'h13;
        i_est_done_fwd <= 1'b1;
        wr(SFP_OFS_MODE, {28'h0, SFP_MODE_AUTO});
        repeat (8) smp(16'h01F4, 1'b0, SFP_ST_PREPARE);
        rdc(SFP_OFS_PROGRESS, 32'h0, "short travel");
        i_travel_revs  <= 32'h14;
        i_est_done_fwd <= 1'b0;
        repeat (8) smp(16'h01F4, 1'b0, SFP_ST_PREPARE);
        rdc(SFP_OFS_PROGRESS, 32'h0, "estimation pending");
        i_est_done_fwd <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            smp(i[0] ? 16'h006E : 16'h005A, 1'b0, SFP_ST_PREPARE);
        end
        repeat (40) @(posedge i_core_clk);
        rdc(SFP_OFS_MODE, 32'h2, "mode after derivation");
        rdc(SFP_OFS_AVERAGE, 32'h64, "derived average");
        rdc(SFP_OFS_STDDEV, 32'hA, "derived deviation");
        rdc(SFP_OFS_PROGRESS, 32'h64, "progress");
        rdc(SFP_OFS_UPPER, 32'h96, "derived upper");
        wr(SFP_OFS_MODE, {28'h0, SFP_MODE_RESET});
        wr(SFP_OFS_CONTROL, 32'h1);
        rdc(SFP_OFS_MODE, 32'h1, "mode after threshold reset");
        wr(SFP_OFS_DIR, 32'h1);
        smp(16'h01F4, 1'b0, SFP_ST_PREPARE);
        rdc(SFP_OFS_PROGRESS, 32'h0, "reverse pending");
        wr(SFP_OFS_MODE, {28'h0, SFP_MODE_OFF});
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_srst <= 1'b0;
        t_regs();
        t_manual();
        t_auto();
        test_done();
    end
endmodule
`default_nettype wire
